/* rtl/cps_pkg.sv */
`default_nettype none
package cps_pkg;
    // Output counts
    localparam int N_SE   = 8;
    localparam int N_DIFF = 3;

    // Reference clock period and derived timing counts
    localparam int CLK_PERIOD_NS   = 20;
    localparam int T_STABLE_NS     = 1800000;
    localparam int T_FLOAT_HIGH_NS = 300000;
    localparam int T_DOWN_INIT_NS  = 10000;
    localparam int STABLE_CYC      = T_STABLE_NS / CLK_PERIOD_NS;
    localparam int FLOAT_HIGH_CYC  = T_FLOAT_HIGH_NS / CLK_PERIOD_NS;
    localparam int DOWN_INIT_CYC   = T_DOWN_INIT_NS / CLK_PERIOD_NS;
    localparam int TMR_W           = 17;

    // Request edges needed before power-down is taken
    localparam logic [1:0] DOWN_EDGES = 2'h2;

    // Sequencer states
    typedef enum logic [2:0] {
        CPS_RUN   = 3'b000,
        CPS_STOP  = 3'b001,
        CPS_OFF   = 3'b010,
        CPS_WAKE  = 3'b011,
        CPS_NOPWR = 3'b100
    } cps_state_t;

    // All sequencer state
    typedef struct packed {
        cps_state_t       st;
        logic             sync1;
        logic             sync2;
        logic             pin_down;
        logic             comp_prev;
        logic [1:0]       edge_cnt;
        logic [TMR_W-1:0] tmr;
        logic             osc_en;
        logic             pll_en;
        logic             stop;
    } cps_seq_t;

    // Gate cell state
    typedef struct packed {
        logic raw_prev;
        logic run;
    } cps_gate_t;
endpackage
`default_nettype wire

/* rtl/cps_clk_gate.sv */
`default_nettype none
// Glitch-free stop and restart of one clock output
module cps_clk_gate (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control and status
    input  wire logic raw,
    input  wire logic stop,
    output logic      run
);
    cps_pkg::cps_gate_t g_r;
    cps_pkg::cps_gate_t g_nxt;

    // Park on a falling edge of the watched leg, resume while it is low
    always_comb begin
        g_nxt          = g_r;
        g_nxt.raw_prev = raw;
        if (stop && g_r.raw_prev && !raw) begin
            g_nxt.run = 1'b0;
        end else if (!stop && !raw) begin
            g_nxt.run = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            g_r <= '0;
        end else begin
            g_r <= g_nxt;
        end
    end

    assign run = g_r.run;

    // Stopping only ever follows a falling edge of the watched leg
    a_stop_on_fall: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(g_r.run) |-> ($past(g_r.raw_prev) && !$past(raw) && $past(stop)))
        else $error("gate parked without a falling edge");
    // Restart only while the watched leg sits at its parked phase
    a_start_low: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(g_r.run) |-> (!$past(raw) && !$past(stop)))
        else $error("gate restarted mid pulse");
endmodule
`default_nettype wire

/* rtl/cps_sequencer.sv */
`default_nettype none
// Behaviour
// - Take request after two high complement edges
// - Single-ended outputs stop low at falling edge
// - Differential pairs stop at complement fall, park
// - Mode 0: true driven high, complement floated
// - Mode 1: both legs high impedance
// - Entry same for every CPU frequency
// - Stable clocks within 1.8 ms
// - Floated pairs driven high within 300 us
// - All outputs enabled together after lock
// - Pin is supply-good until first seen low
// - Synchronise request, park before oscillator off
// - Per-group drive-mode bit, 0 driven
module cps_sequencer #(
    parameter int STABLE_CYC = cps_pkg::STABLE_CYC
) (
    // Clock and reset
    input  wire logic                      REF_CLK,
    input  wire logic                      RSTN,
    // Combined supply-good / power-down pin
    input  wire logic                      SUPPLY_GOOD_N_DOWN_REQ,
    // Free-running sources from the synthesizer
    input  wire logic                      CPU_CLOCK_COMPLEMENT_RAW,
    input  wire logic [cps_pkg::N_SE-1:0]   SE_CLK_RAW,
    input  wire logic [cps_pkg::N_DIFF-1:0] DIFF_C_RAW,
    // Per-group drive mode
    input  wire logic [cps_pkg::N_DIFF-1:0] DIFF_HIZ_MODE,
    // Oscillator and PLL control
    input  wire logic                      PLL_LOCK,
    output logic                           OSC_EN,
    output logic                           PLL_EN,
    // Gated outputs
    output logic [cps_pkg::N_SE-1:0]        SE_CLK_OUT,
    output logic [cps_pkg::N_DIFF-1:0]      DIFF_T,
    output logic [cps_pkg::N_DIFF-1:0]      DIFF_C,
    output logic [cps_pkg::N_DIFF-1:0]      DIFF_T_OE_N,
    output logic [cps_pkg::N_DIFF-1:0]      DIFF_C_OE_N,
    output logic [cps_pkg::N_DIFF-1:0]      DIFF_DRIVE_2X,
    output logic                           CLOCKS_STABLE
);
    localparam logic [cps_pkg::TMR_W-1:0] STABLE_MAX = cps_pkg::TMR_W'(STABLE_CYC);

    cps_pkg::cps_seq_t s_r;
    cps_pkg::cps_seq_t s_nxt;
    logic [cps_pkg::N_SE-1:0]   se_run;
    logic [cps_pkg::N_DIFF-1:0] diff_run;
    logic                       all_parked;
    logic                       req;
    logic                       comp_rise;
    logic                       down_state;

    assign all_parked = ~|se_run && ~|diff_run;
    assign req        = s_r.sync2;
    assign comp_rise  = CPU_CLOCK_COMPLEMENT_RAW && !s_r.comp_prev;
    assign down_state = (s_r.st == cps_pkg::CPS_STOP) || (s_r.st == cps_pkg::CPS_OFF);

    // Sequencer next state
    always_comb begin
        s_nxt           = s_r;
        s_nxt.sync1     = SUPPLY_GOOD_N_DOWN_REQ;
        s_nxt.sync2     = s_r.sync1;
        s_nxt.comp_prev = CPU_CLOCK_COMPLEMENT_RAW;
        // Count complement rising edges with request high, any frequency
        if (!req) begin
            s_nxt.edge_cnt = 2'h0;
        end else if (comp_rise && s_r.edge_cnt != cps_pkg::DOWN_EDGES) begin
            s_nxt.edge_cnt = s_r.edge_cnt + 2'h1;
        end
        case (s_r.st)
            cps_pkg::CPS_NOPWR: begin
                // Pin read as supply-good until first low
                if (!req) begin
                    s_nxt.pin_down = 1'b1;
                    s_nxt.st     = cps_pkg::CPS_WAKE;
                    s_nxt.osc_en = 1'b1;
                    s_nxt.pll_en = 1'b1;
                    s_nxt.tmr    = '0;
                end
            end
            cps_pkg::CPS_RUN: begin
                if (s_r.edge_cnt == cps_pkg::DOWN_EDGES) begin
                    s_nxt.st   = cps_pkg::CPS_STOP;
                    s_nxt.stop = 1'b1;
                end
            end
            cps_pkg::CPS_STOP: begin
                // Oscillator stays on until every output is parked
                if (all_parked) begin
                    s_nxt.st     = cps_pkg::CPS_OFF;
                    s_nxt.osc_en = 1'b0;
                    s_nxt.pll_en = 1'b0;
                end
            end
            cps_pkg::CPS_OFF: begin
                if (!req) begin
                    s_nxt.st     = cps_pkg::CPS_WAKE;
                    s_nxt.osc_en = 1'b1;
                    s_nxt.pll_en = 1'b1;
                    s_nxt.tmr    = '0;
                end
            end
            cps_pkg::CPS_WAKE: begin
                s_nxt.tmr = s_r.tmr + 1'b1;
                if (req) begin
                    s_nxt.st = cps_pkg::CPS_STOP;         // Early request at power-on
                end else if (PLL_LOCK || s_r.tmr >= STABLE_MAX - 1'b1) begin
                    s_nxt.st   = cps_pkg::CPS_RUN;
                    s_nxt.stop = 1'b0;
                end
            end
            default: begin
                s_nxt.st = cps_pkg::CPS_NOPWR;
            end
        endcase
    end

    // State register
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            s_r       <= '0;
            s_r.st    <= cps_pkg::CPS_NOPWR;
            s_r.sync1 <= 1'b1;
            s_r.sync2 <= 1'b1;
            s_r.stop  <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // One gate per output, single-ended on its own leg, pairs on complement
    genvar i;
    generate
        for (i = 0; i < cps_pkg::N_SE + cps_pkg::N_DIFF; i++) begin : g_gate
            if (i < cps_pkg::N_SE) begin : g_se
                cps_clk_gate u_gate (
                    .clk   (REF_CLK),
                    .rst_n (RSTN),
                    .raw   (SE_CLK_RAW[i]),
                    .stop  (s_r.stop),
                    .run   (se_run[i])
                );
            end else begin : g_diff
                cps_clk_gate u_gate (
                    .clk   (REF_CLK),
                    .rst_n (RSTN),
                    .raw   (DIFF_C_RAW[i-cps_pkg::N_SE]),
                    .stop  (s_r.stop),
                    .run   (diff_run[i-cps_pkg::N_SE])
                );
            end
        end
    endgenerate

    // Output levels and enables
    always_comb begin
        SE_CLK_OUT    = SE_CLK_RAW & se_run;
        DIFF_T        = ~DIFF_C_RAW | ~diff_run;
        DIFF_C        = DIFF_C_RAW & diff_run;
        DIFF_T_OE_N   = {cps_pkg::N_DIFF{down_state}} & ~diff_run & DIFF_HIZ_MODE;
        DIFF_C_OE_N   = {cps_pkg::N_DIFF{down_state}} & ~diff_run;
        DIFF_DRIVE_2X = ~diff_run & ~DIFF_T_OE_N;
    end

    assign OSC_EN        = s_r.osc_en;
    assign PLL_EN        = s_r.pll_en;
    assign CLOCKS_STABLE = (s_r.st == cps_pkg::CPS_RUN);

    // Power-down taken only after two counted complement edges
    a_entry_two_edges: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (s_r.st == cps_pkg::CPS_STOP && $past(s_r.st) == cps_pkg::CPS_RUN)
        |-> $past(s_r.edge_cnt) == cps_pkg::DOWN_EDGES)
        else $error("power-down taken before two edges");
    // Oscillator only turned off with every output parked
    a_park_before_off: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        $fell(OSC_EN) |-> $past(all_parked) && $past(s_r.st) == cps_pkg::CPS_STOP)
        else $error("oscillator off with an output running");
    // Parked single-ended outputs stay low
    a_se_held_low: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        ($past(s_r.stop) && ~|$past(se_run)) |-> (SE_CLK_OUT == '0 && ~|se_run))
        else $error("single-ended output not low while parked");
    // Mode 1 floats both legs of a parked group
    a_float_mode1: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (s_r.st == cps_pkg::CPS_OFF && DIFF_HIZ_MODE[0])
        |-> DIFF_T_OE_N[0] && DIFF_C_OE_N[0])
        else $error("mode 1 group not floated");
    // Mode 0 drives true high, floats complement
    a_drive_mode0: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (s_r.st == cps_pkg::CPS_OFF && !DIFF_HIZ_MODE[0])
        |-> !DIFF_T_OE_N[0] && DIFF_T[0] && DIFF_DRIVE_2X[0] && DIFF_C_OE_N[0])
        else $error("mode 0 group not parked high");
    // Floated pairs driven again the cycle after release
    a_wake_driven: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (s_r.st == cps_pkg::CPS_WAKE) |-> DIFF_T_OE_N == '0 && DIFF_T == '1)
        else $error("pair left floating after release");
    // Lock releases every output in one step
    a_lock_release: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (s_r.st == cps_pkg::CPS_WAKE && PLL_LOCK && !req) |=> !s_r.stop)
        else $error("outputs not released after lock");
    // Wake never outlasts the stabilisation bound
    a_stable_bound: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        (s_r.st == cps_pkg::CPS_WAKE) |-> s_r.tmr < STABLE_MAX)
        else $error("stabilisation time exceeded");
    // Pin function never returns to supply-good
    a_pin_mode: assert property (@(posedge REF_CLK) disable iff (!RSTN)
        !$fell(s_r.pin_down))
        else $error("pin reverted to supply-good");
endmodule
`default_nettype wire

/* rtl/unused_placeholder_none.sv */
`default_nettype none
`default_nettype wire

/* verification/cps_pm_model.sv */
`default_nettype none
// Power manager and free-running clock sources facing the sequencer
module cps_pm_model (
    // Clock
    input  wire logic                       REF_CLK,
    // Combined pin and raw sources
    output wire logic                       SUPPLY_GOOD_N_DOWN_REQ,
    output wire logic                       CPU_CLOCK_COMPLEMENT_RAW,
    output wire logic [cps_pkg::N_SE-1:0]   SE_CLK_RAW,
    output wire logic [cps_pkg::N_DIFF-1:0] DIFF_C_RAW
);
    timeunit 1ns;
    timeprecision 100ps;
    int         half   = 2;
    int         cnt    = 0;
    logic       pin_q  = 1'b1;
    logic       comp_q = 1'b0;
    logic [7:0] div_q  = 8'h00;
    // Complement toggles every half cycles, the rest from a divider
    always @(posedge REF_CLK) begin
        cnt <= (cnt + 1 >= half) ? 0 : cnt + 1;
        if (cnt + 1 >= half) begin
            comp_q <= ~comp_q;
        end
        div_q <= div_q + 8'h01;
    end
    // Pin and source levels
    assign SUPPLY_GOOD_N_DOWN_REQ   = pin_q;
    assign CPU_CLOCK_COMPLEMENT_RAW = comp_q;
    assign SE_CLK_RAW               = {div_q[4:1], div_q[3:0]};
    assign DIFF_C_RAW               = div_q[3:1];
    // Supply good: pin pulled low once
    task supply_good();
        pin_q = 1'b0;
    endtask
    // Power-down request level
    task set_down_req(input logic v);
        pin_q = v;
    endtask
    // Power-down as first state: request soon after supply good
    task power_on_down();
        pin_q = 1'b0;
        repeat (20) @(posedge REF_CLK);
        #1;
        pin_q = 1'b1;
    endtask
endmodule
`default_nettype wire

/* verification/tb_cps_sequencer.sv */
`default_nettype none
`define CHK(got, want) begin n_tests++; if ((got) !== (want)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, got, want); end end
`define WAIT(c, n) for (i = 0; i < (n) && !(c); i++) tick(1);
module tb_cps_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int STAB = 50;
    logic       REF_CLK = 1'b0;
    logic       RSTN    = 1'b0;
    logic [2:0] DIFF_HIZ_MODE = 3'h0;
    logic       PLL_LOCK = 1'b0;
    wire logic  DOWN_PIN, CPU_COMP_RAW, OSC_EN, PLL_EN, CLOCKS_STABLE;
    wire logic [7:0] SE_CLK_RAW, SE_CLK_OUT;
    wire logic [2:0] DIFF_C_RAW, DIFF_T, DIFF_C, DIFF_T_OE_N, DIFF_C_OE_N, DIFF_DRIVE_2X;
    int         errors = 0;
    int         n_tests = 0;
    int         cyc = 0;
    int         i;
    int         k;
    logic [7:0] so_q = 8'h00;
    logic [7:0] sr_q = 8'h00;
    logic [2:0] co_q = 3'h0;
    logic [2:0] cr_q = 3'h0;
    // Far side and device
    cps_pm_model pm (.REF_CLK(REF_CLK), .SUPPLY_GOOD_N_DOWN_REQ(DOWN_PIN),
        .CPU_CLOCK_COMPLEMENT_RAW(CPU_COMP_RAW), .SE_CLK_RAW(SE_CLK_RAW), .DIFF_C_RAW(DIFF_C_RAW));
    cps_sequencer #(.STABLE_CYC(STAB)) dut (.REF_CLK(REF_CLK), .RSTN(RSTN),
        .SUPPLY_GOOD_N_DOWN_REQ(DOWN_PIN), .CPU_CLOCK_COMPLEMENT_RAW(CPU_COMP_RAW),
        .SE_CLK_RAW(SE_CLK_RAW),
        .DIFF_C_RAW(DIFF_C_RAW), .DIFF_HIZ_MODE(DIFF_HIZ_MODE), .PLL_LOCK(PLL_LOCK),
        .OSC_EN(OSC_EN), .PLL_EN(PLL_EN), .SE_CLK_OUT(SE_CLK_OUT), .DIFF_T(DIFF_T),
        .DIFF_C(DIFF_C), .DIFF_T_OE_N(DIFF_T_OE_N), .DIFF_C_OE_N(DIFF_C_OE_N),
        .DIFF_DRIVE_2X(DIFF_DRIVE_2X), .CLOCKS_STABLE(CLOCKS_STABLE));
    // Clock
    initial begin
        forever #10 REF_CLK = ~REF_CLK;
    end
    // Verdict and end of run
    task finish_test();
        $display("errors %0d, n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge REF_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            finish_test();
        end
    end
    // Single-ended and complement outputs switch only with their source: no short pulses
    always @(posedge REF_CLK) begin
        #1;
        if (RSTN) begin
            `CHK((SE_CLK_OUT & ~so_q & sr_q) | (~SE_CLK_OUT & so_q & SE_CLK_RAW), 8'h00)
            `CHK((DIFF_C & ~co_q & cr_q) | (~DIFF_C & co_q & DIFF_C_RAW), 3'h0)
        end
        so_q = SE_CLK_OUT;
        sr_q = SE_CLK_RAW;
        co_q = DIFF_C;
        cr_q = DIFF_C_RAW;
    end
    // Step n edges, land just after the last
    task tick(input int n);
        repeat (n) begin
            @(posedge REF_CLK);
            #1;
        end
    endtask
    // Outputs follow the sources
    task check_run();
        `CHK(SE_CLK_OUT, SE_CLK_RAW)
        `CHK({DIFF_T, DIFF_C}, {~DIFF_C_RAW, DIFF_C_RAW})
        `CHK(DIFF_T_OE_N | DIFF_C_OE_N, 3'h0)
    endtask
    // Parked state for a drive mode
    task check_off(input logic [2:0] m);
        `CHK(SE_CLK_OUT, 8'h00)
        `CHK(DIFF_T | m, 3'h7)
        `CHK(DIFF_T_OE_N, m)
        `CHK(DIFF_C_OE_N, 3'h7)
        `CHK(DIFF_DRIVE_2X, ~m)
        `CHK({OSC_EN, PLL_EN, CLOCKS_STABLE}, 3'h0)
    endtask
    // Main sequence
    initial begin
        tick(6);
        RSTN = 1'b1;
        tick(10);
        `CHK(OSC_EN, 1'b0)
        pm.supply_good();
        `WAIT(OSC_EN, 4)
        `CHK({OSC_EN, PLL_EN}, 2'h3)
        PLL_LOCK = 1'b1;
        `WAIT(CLOCKS_STABLE, 4)
        `CHK(CLOCKS_STABLE, 1'b1)
        for (k = 0; k < 2; k++) begin
            pm.half = k ? 5 : 2;
            DIFF_HIZ_MODE = k ? 3'h5 : 3'h2;
            tick(20);
            check_run();
            pm.set_down_req(1'b1);
            tick(2 * pm.half - 1);
            pm.set_down_req(1'b0);
            tick(2 * pm.half + 4);
            `CHK(CLOCKS_STABLE, 1'b1)
            pm.set_down_req(1'b1);
            tick(2 * pm.half);
            `CHK(CLOCKS_STABLE, 1'b1)
            `WAIT(!CLOCKS_STABLE, 4 * pm.half + 8)
            `CHK(CLOCKS_STABLE, 1'b0)
            PLL_LOCK = 1'b0;
            `WAIT(!OSC_EN, 80)
            tick(2);
            check_off(DIFF_HIZ_MODE);
            pm.set_down_req(1'b0);
            tick(4);
            `CHK(DIFF_T_OE_N | DIFF_C_OE_N, 3'h0)
            `CHK({OSC_EN, PLL_EN, CLOCKS_STABLE}, 3'h6)
            if (k == 0) begin
                PLL_LOCK = 1'b1;
                `WAIT(CLOCKS_STABLE, 4)
            end else begin
                `WAIT(CLOCKS_STABLE, STAB + 4)
            end
            `CHK(CLOCKS_STABLE, 1'b1)
            tick(40);
            check_run();
        end
        // Second reset, power-down wanted as the first state
        RSTN = 1'b0;
        PLL_LOCK = 1'b0;
        pm.set_down_req(1'b1);
        tick(6);
        RSTN = 1'b1;
        pm.power_on_down();
        `WAIT(!OSC_EN, 80)
        tick(2);
        check_off(DIFF_HIZ_MODE);
        finish_test();
    end
endmodule
`default_nettype wire
